// ===== include/sercp_consts.vh
// Constants for the serial EEPROM read and write-protect block
`ifndef SERCP_CONSTS_VH
`define SERCP_CONSTS_VH
// Clock and rewrite interval
`define SERCP_PCLK_PERIOD_NS 5
`define SERCP_TWR_NS         1000000
// Device code in the top nibble of the address byte
`define SERCP_DEVICE_CODE    4'ha
// APB register byte offsets
`define SERCP_REG_MEM_ADDR   8'h00
`define SERCP_REG_MEM_DATA   8'h04
`define SERCP_REG_STATUS     8'h08
// Status register fields
`define SERCP_ST_BUSY_BIT    31
`define SERCP_ST_STATE_LSB   16
`define SERCP_ST_CNT_LSB     0
`endif

// ===== sim/sercp_eeprom_properties.sv
// Port-level checks for the serial EEPROM block
`timescale 1ns/1ps
`default_nettype none
module sercp_eeprom_properties #(
    parameter integer KBITS      = 4,
    parameter integer TWR_CYCLES = 50
) (
    // Clock, reset and APB
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        pready, pslverr,
    // Link and straps
    input wire logic        scl_in, sda_in, sda_out, sda_oe,
    input wire logic        write_protect, select_pin_bit0, select_pin_bit1, select_pin_bit2
);
    int busy_left;
    // Rewrite cycles still to run after a commit cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_left <= 0;
        else if (!pready) busy_left <= TWR_CYCLES;
        else if (busy_left > 0) busy_left <= busy_left - 1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup phase of an APB transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    a_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_oe_clock_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data drive changed with clock high");
    a_oe_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data drive moved during clock high");
    a_no_ack_busy: assert property (busy_left > 0 |-> !sda_oe)
        else $error("answer during rewrite");
    a_wait_one: assert property (!pready |=> pready)
        else $error("wait state longer than one cycle");
    a_slverr_bad: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08})
        |-> pslverr) else $error("unmapped access not refused");
    a_slverr_good: assert property (psel && penable && (paddr inside {8'h00, 8'h04, 8'h08})
        |-> !pslverr) else $error("mapped access refused");
    a_unmapped_zero: assert property (s_setup ##1 (penable && !pwrite && pslverr)
        |-> prdata == 32'h0) else $error("unmapped read not zero");
endmodule
bind sercp_eeprom sercp_eeprom_properties #(.KBITS(KBITS), .TWR_CYCLES(TWR_CYCLES)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .select_pin_bit0(select_pin_bit0),
    .select_pin_bit1(select_pin_bit1), .select_pin_bit2(select_pin_bit2));
`default_nettype wire

// ===== sim/sercp_master.sv
// Two-wire bus master model driving the link clock and data line
`timescale 1ns/1ps
`default_nettype none
module sercp_master (
    // Link lines
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    // Both lines released while idle, clock stands high
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Start or repeated start
    task start;
        #12 sda_m = 1'b1;
        #12 scl = 1'b1;
        #12 sda_m = 1'b0;
        #12 scl = 1'b0;
    endtask
    // Stop, clock left standing high
    task stop;
        #12 sda_m = 1'b0;
        #12 scl = 1'b1;
        #12 sda_m = 1'b1;
        #12;
    endtask
    // One bit: data set mid-low, sampled at the end of high
    task bit_io(input logic b, output logic r);
        #12 sda_m = b;
        #12 scl = 1'b1;
        #24 r = sda;
        scl = 1'b0;
    endtask
    // Eight bits MSB first and the acknowledge slot
    task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask
endmodule
`default_nettype wire

// ===== sim/serial_eeprom_read_protect_tb_top.sv
// Self-checking bench for the serial EEPROM read and protect block
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_protect_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, b;
    logic [31:0] pwdata, prdata, q;
    logic        sda_out, sda_oe, scl, sda_m, wp, err, ack;
    int          num_errors, comparisons, cycles = 0;
    logic [8:0]  fill [5] = '{9'h1fe, 9'h1ff, 9'h000, 9'h110, 9'h11f};
    wire         sda;
    // Wired line with pull-up
    assign sda = sda_m & ~(sda_oe & ~sda_out);
    sercp_eeprom #(.KBITS(4), .TWR_CYCLES(400)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(wp),
        .select_pin_bit0(1'b1), .select_pin_bit1(1'b1), .select_pin_bit2(1'b0));
    sercp_master i_mst (.scl(scl), .sda_m(sda_m), .sda(sda));
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // APB transfer; read data and error taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task mem_check(input logic [8:0] a, input logic [7:0] exp);
        apb(1'b1, 8'h00, {23'h0, a});
        apb(1'b0, 8'h04, 32'h0);
        check(q, {24'h0, exp});
    endtask
    task sb(input logic [7:0] d, input logic exp_ack);
        i_mst.xfer(d, 1'b1, b, ack);
        check(ack, exp_ack);
    endtask
    task rb(input logic ack_in, input logic [7:0] exp);
        i_mst.xfer(8'hff, ack_in, b, ack);
        check(b, exp);
    endtask
    task cnt_check(input logic [8:0] exp);
        apb(1'b0, 8'h08, 32'h0);
        check({23'h0, q[8:0]}, exp);
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize;
        end
    end
    // Main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h0; pwdata = 32'h0; wp = 1'b0; num_errors = 0; comparisons = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        foreach (fill[i]) begin
            apb(1'b1, 8'h00, {23'h0, fill[i]});
            apb(1'b1, 8'h04, {24'h0, fill[i][7:0] ^ 8'h3c});
        end
        i_mst.start;
        sb(8'ha6, 1'b0);
        sb(8'hfe, 1'b0);
        i_mst.start;
        sb(8'ha5, 1'b0);
        rb(1'b0, 8'hc2);
        rb(1'b0, 8'hc3);
        rb(1'b1, 8'h3c);
        i_mst.stop;
        cnt_check(9'h001);
        mem_check(9'h1fe, 8'hc2);
        i_mst.start;
        sb(8'ha6, 1'b0);
        sb(8'hfe, 1'b0);
        i_mst.start;
        sb(8'ha5, 1'b0);
        rb(1'b0, 8'hc2);
        i_mst.stop;
        apb(1'b0, 8'h08, 32'h0);
        check({29'h0, q[18:16]}, 32'h0);
        check({23'h0, q[8:0]}, 32'h1ff);
        $display("random read done");
        i_mst.start;
        sb(8'ha0, 1'b1);
        i_mst.stop;
        apb(1'b0, 8'h0c, 32'h0);
        check(err, 1'b1);
        check(q, 32'h0);
        $display("refusals done");
        @(posedge pclk) wp <= 1'b1;
        i_mst.start;
        sb(8'ha6, 1'b0);
        sb(8'h10, 1'b0);
        sb(8'h99, 1'b0);
        sb(8'h98, 1'b0);
        i_mst.stop;
        i_mst.start;
        sb(8'ha5, 1'b1);
        i_mst.stop;
        repeat (450) @(posedge pclk);
        cnt_check(9'h112);
        mem_check(9'h110, 8'h2c);
        $display("protected write done");
        @(posedge pclk) wp <= 1'b0;
        i_mst.start;
        sb(8'ha6, 1'b0);
        sb(8'h1f, 1'b0);
        sb(8'h55, 1'b0);
        sb(8'h66, 1'b0);
        i_mst.stop;
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        check(q[31], 1'b1);
        repeat (450) @(posedge pclk);
        cnt_check(9'h111);
        mem_check(9'h11f, 8'h55);
        mem_check(9'h110, 8'h66);
        $display("open write done");
        summarize;
    end
endmodule
`default_nettype wire

// ===== verilog/sercp_eeprom.v
// Two-wire serial EEPROM slave: address counter, reads, write protection, APB window
//
// Contract
// - Write-protect high blocks upper-half programming from the link (APB writes pass), except at 1 kbit where nothing is locked
// - Blocked write still starts rewrite interval, busy
// - Write-protect low lets every location program
// - Address counter persists across all transactions
// - Read address acks, streams byte at counter
// - Current read ignores page bit, uses counter
// - Read counter increments on seventh-bit falling edge
// - Write increments only page-offset counter bits
// - Dummy write loads word address into counter
// - Dummy write programs nothing, only loads counter
// - Master ack continues with next byte
// - Sequential read wraps past top to zero
// - Write counter increments on eighth-bit capture fall
// - Start and stop decoded while clock high
// - Respond only to code 1010 and pins
// - Ack on ninth clock, none while rewriting
// - Stop during read aborts to standby
`timescale 1ns/1ps
`default_nettype none
`include "sercp_consts.vh"

module sercp_eeprom #(
    parameter integer KBITS      = 4,
    parameter integer TWR_CYCLES = `SERCP_TWR_NS / `SERCP_PCLK_PERIOD_NS
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Two-wire link
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    // Straps
    input  wire        write_protect,
    input  wire        select_pin_bit0,
    input  wire        select_pin_bit1,
    input  wire        select_pin_bit2
);
    // Capacity-derived widths
    localparam integer AW = (KBITS == 1) ? 7 : (KBITS == 2) ? 8 : 9;
    localparam integer PB = (KBITS == 4) ? 4 : 3;
    localparam integer DEPTH = 1 << AW;
    localparam integer PAGE = 1 << PB;

    // Protocol states; the code is visible in the status word
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_DEV   = 3'h1;
    localparam [2:0] ST_WORD  = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_RDATA = 3'h4;

    // Storage, pin stages and protocol state
    reg  [7:0]    mem [0:DEPTH-1];
    reg  [7:0]    pbuf [0:PAGE-1];
    reg  [PAGE-1:0] pvalid;
    reg  [5:0]    sync1;
    reg  [5:0]    sync2;
    reg  [1:0]    prev;
    reg  [2:0]    state;
    reg  [3:0]    bitcnt;
    reg  [7:0]    shreg;
    reg  [AW-1:0] cnt;
    reg           upper_page_bit;
    reg           ack_given;
    reg           busy;
    reg  [23:0]   timer;
    reg  [AW-1:0] mem_addr;
    reg           commit;
    integer       i;

    // Synchronised pins and bus condition decode
    wire scl_s = sync2[0];
    wire sda_s = sync2[1];
    wire wp_s  = sync2[2];
    wire [2:0] sel_s = sync2[5:3];
    wire scl_rise = scl_s & ~prev[0];
    wire scl_fall = ~scl_s & prev[0];
    wire start_det = scl_s & prev[0] & prev[1] & ~sda_s;
    wire stop_det  = scl_s & prev[0] & ~prev[1] & sda_s;
    wire [7:0] rd_byte = mem[cnt];
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite & pready;
    // Word address as received, page bit on top; cut to the counter width
    wire [8:0] word_load = {upper_page_bit, shreg};

    // Upper half is locked only when protection exists and the strap is high
    function is_protected;
        input [AW-1:0] addr;
        input          wp;
        begin
            is_protected = (KBITS != 1) & wp & addr[AW-1];
        end
    endfunction

    // Address byte match: device code plus select pins, page bit not compared on 4 kbit
    function addr_match;
        input [7:0] a;
        input [2:0] sel;
        begin
            addr_match = (a[7:4] == `SERCP_DEVICE_CODE) & (a[3:2] == sel[2:1]) &
                         ((KBITS == 4) | (a[1] == sel[0]));
        end
    endfunction

    // Address acknowledge: refused while a rewrite is running
    wire dev_ack = addr_match(shreg, sel_s) & ~busy;

    // Open-drain data line: the only level ever driven is low
    assign sda_out = 1'b0;

    // Pin synchronisers; only the second stage is read by logic
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 6'h03;
            sync2 <= 6'h03;
            prev  <= 2'h3;
        end else begin
            sync1 <= {select_pin_bit2, select_pin_bit1, select_pin_bit0,
                      write_protect, sda_in, scl_in};
            sync2 <= sync1;
            prev  <= {sda_s, scl_s};
        end
    end

    // Two-wire protocol engine and counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_IDLE;
            bitcnt         <= 4'h0;
            shreg          <= 8'h00;
            cnt            <= {AW{1'b0}};
            upper_page_bit <= 1'b0;
            ack_given      <= 1'b0;
            sda_oe         <= 1'b0;
            pvalid         <= {PAGE{1'b0}};
            commit         <= 1'b0;
        end else begin
            commit <= 1'b0;
            // Clear after a commit first, so a byte captured in the same cycle keeps its flag
            if (commit) begin
                pvalid <= {PAGE{1'b0}};
            end
            if (stop_det) begin
                // Stop: reads abort, received write data starts the rewrite
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
                if (|pvalid) begin
                    commit <= 1'b1;
                end
            end else if (start_det) begin
                // Start or repeated start: a fresh address byte follows
                state  <= ST_DEV;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (state != ST_IDLE && scl_rise) begin
                if (bitcnt == 4'h8) begin
                    bitcnt <= 4'h0;
                    case (state)
                        ST_DEV: begin
                            // Direction bit picks streaming or a word address
                            if (!ack_given) begin
                                state <= ST_IDLE;
                            end else if (shreg[0]) begin
                                state <= ST_RDATA;
                            end else begin
                                state          <= ST_WORD;
                                upper_page_bit <= shreg[1];
                                pvalid         <= {PAGE{1'b0}};
                            end
                        end
                        ST_WORD: begin
                            cnt   <= word_load[AW-1:0];
                            state <= ST_WDATA;
                        end
                        ST_RDATA: begin
                            // Master's ninth bit: high ends the stream, low asks for more
                            if (sda_s) begin
                                state <= ST_IDLE;
                            end
                        end
                        default: begin
                            state <= state;
                        end
                    endcase
                end else begin
                    // Bits one to eight shift in on the rise; reads shift nothing
                    bitcnt <= bitcnt + 4'h1;
                    if (state != ST_RDATA) begin
                        shreg <= {shreg[6:0], sda_s};
                    end
                end
            end else if (state != ST_IDLE && scl_fall) begin
                if (state == ST_RDATA) begin
                    // Next bit goes out while the clock is low; counter moves as bit zero goes out
                    if (bitcnt == 4'h8) begin
                        sda_oe <= 1'b0; // Released for the master's ack
                    end else begin
                        sda_oe <= ~rd_byte[3'h7 - bitcnt[2:0]];
                        if (bitcnt == 4'h7) begin
                            cnt <= cnt + {{(AW-1){1'b0}}, 1'b1};
                        end
                    end
                end else if (bitcnt == 4'h8) begin
                    // Ninth clock: acknowledge received byte
                    if (state == ST_DEV) begin
                        ack_given <= dev_ack;
                        sda_oe    <= dev_ack;
                    end else begin
                        sda_oe <= 1'b1;
                    end
                    if (state == ST_WDATA) begin
                        pbuf[cnt[PB-1:0]]   <= shreg;
                        pvalid[cnt[PB-1:0]] <= 1'b1;
                        cnt[PB-1:0]         <= cnt[PB-1:0] + {{(PB-1){1'b0}}, 1'b1};
                    end
                end else begin
                    // Outside the ack slot a receiver leaves the line released
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    // Rewrite interval: no acknowledge until it has run out
    // No commit can arrive while busy, since the address byte is not acknowledged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy  <= 1'b0;
            timer <= 24'h000000;
        end else if (commit) begin
            busy  <= 1'b1;
            timer <= TWR_CYCLES[23:0];
        end else if (busy) begin
            timer <= timer - 24'h000001;
            if (timer == 24'h000001) begin
                busy <= 1'b0;
            end
        end
    end

    // Memory array: page commit from the link, single-byte writes from APB
    // Contents are not reset; unwritten locations read back unknown
    always @(posedge pclk) begin
        if (commit) begin
            for (i = 0; i < PAGE; i = i + 1) begin
                if (pvalid[i] &&
                    !is_protected({cnt[AW-1:PB], i[PB-1:0]}, wp_s)) begin
                    mem[{cnt[AW-1:PB], i[PB-1:0]}] <= pbuf[i];
                end
            end
        end else if (apb_wr && paddr == `SERCP_REG_MEM_DATA) begin
            mem[mem_addr] <= pwdata[7:0];
        end
    end

    // APB slave: one access cycle, stalled only in the commit cycle
    assign pready  = ~commit;
    assign pslverr = psel & penable & (paddr != `SERCP_REG_MEM_ADDR) &
                     (paddr != `SERCP_REG_MEM_DATA) & (paddr != `SERCP_REG_STATUS);

    // APB register writes and registered read data
    // Read data is taken in the setup cycle and stands for the whole access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr <= {AW{1'b0}};
            prdata   <= 32'h00000000;
        end else begin
            if (apb_wr && paddr == `SERCP_REG_MEM_ADDR) begin
                mem_addr <= pwdata[AW-1:0];
            end
            if (apb_setup) begin
                if (paddr == `SERCP_REG_MEM_ADDR) begin
                    prdata <= {{(32-AW){1'b0}}, mem_addr};
                end else if (paddr == `SERCP_REG_MEM_DATA) begin
                    prdata <= {24'h000000, mem[mem_addr]};
                end else if (paddr == `SERCP_REG_STATUS) begin
                    prdata <= ({31'h0, busy} << `SERCP_ST_BUSY_BIT) |
                              ({29'h0, state} << `SERCP_ST_STATE_LSB) |
                              ({{(32-AW){1'b0}}, cnt} << `SERCP_ST_CNT_LSB);
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end
endmodule
`default_nettype wire
